// *** rtl/dar_top.v ***
// Purpose: I2C slave with program and application addresses plus ranging
//          sequencer for an ultrasonic time-of-flight sensor.
// Assumes: SCL, SDA, echo and interrupt pins are asynchronous to clk.
// Notes:   Open-drain pins drive low only while their enable is high.
`timescale 1ns/1ns
`include "dar_consts.vh"

module dar_top (
  input  wire        clk,
  input  wire        nrst,
  input  wire        scl_in,
  output wire        scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  input  wire        int_in,
  output reg         int_out,
  output wire        int_oe,
  input  wire        echo_in,
  output reg         tx_burst,
  output reg  [15:0] range_mm,
  output reg         fw_loaded,
  output reg  [6:0]  app_addr,
  input  wire [5:0]  fw_rd_addr,
  output reg  [7:0]  fw_rd_data
);

  localparam [7:0] S_IDLE = 8'h01, S_RX = 8'h02, S_RXHOLD = 8'h04,
                   S_RXACK = 8'h08, S_TX = 8'h10, S_TXHOLD = 8'h20,
                   S_TXACK = 8'h40, S_WAIT = 8'h80;
  localparam [3:0] M_IDLE = 4'h1, M_DELAY = 4'h2, M_BURST = 4'h4,
                   M_LISTEN = 4'h8;
  // Counts are worked out at full width, then cut to their counters
  localparam integer STRETCH_N = `DAR_STRETCH_CYC - 1;
  localparam integer TICK_N    = `DAR_TICK_CYC - 1;
  localparam integer MS_N      = `DAR_TICKS_PER_MS - 1;
  localparam integer TRIG_N    = `DAR_TRIG_CYC - 1;
  localparam integer INT_N     = `DAR_INT_CYC;
  localparam [4:0] STRETCH_END = STRETCH_N[4:0];
  localparam [6:0] TICK_END    = TICK_N[6:0];
  localparam [9:0] MS_END      = MS_N[9:0];
  localparam [9:0] TRIG_END    = TRIG_N[9:0];
  localparam [6:0] INT_LEN     = INT_N[6:0];

  function [15:0] tof_to_mm;
    input [15:0] t;
    reg   [25:0] p;
    reg   [25:0] q;
    begin
      p = {10'h000, t} * `DAR_SOUND_MPS;
      q = p / `DAR_MM_DIV;
      tof_to_mm = q[15:0];
    end
  endfunction

  function [15:0] cm_to_round_us;
    input [7:0]  cm;
    reg   [23:0] p;
    reg   [23:0] q;
    begin
      p = {16'h0000, cm} * `DAR_CM_TO_US_MUL;
      q = p / `DAR_SOUND_MPS24;
      cm_to_round_us = q[15:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  reg  [1:0] rst_q;
  wire       rst_n = rst_q[1];
  reg  [2:0] scl_q;
  reg  [2:0] sda_q;
  reg  [2:0] int_q;
  reg  [1:0] echo_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) rst_q <= 2'h0;
    else       rst_q <= {rst_q[0], 1'b1};
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q  <= 3'h7;
      sda_q  <= 3'h7;
      int_q  <= 3'h0;
      echo_q <= 2'h0;
    end else begin
      scl_q  <= {scl_q[1:0], scl_in};
      sda_q  <= {sda_q[1:0], sda_in};
      int_q  <= {int_q[1:0], int_in};
      echo_q <= {echo_q[0], echo_in};
    end
  end

  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  wire bus_stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  // Open drain: only ever pull low; the device never masters the bus
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave
  reg [7:0]  state;
  reg [3:0]  bitcnt;
  reg [7:0]  sreg;
  reg [7:0]  txbuf;
  reg [4:0]  hold;
  reg        first;
  reg        is_read;
  reg        to_prog;
  reg        ack_bit;
  reg        m_ack;
  reg [2:0]  ptr;
  reg        ptr_set;
  reg [6:0]  pm_ptr;
  reg        pm_wrote;
  reg [7:0]  ctrl;
  reg [7:0]  fsd;
  reg [7:0]  period;
  reg [7:0]  thresh;
  reg [6:0]  addr_pend;
  reg        addr_upd;
  reg        rd_clr;
  reg [7:0]  pmem [0:`DAR_PMEM_DEPTH-1];
  reg [7:0]  rd_data;
  reg        new_flag;
  reg        busy;
  reg        reg_ok;

  wire prog_hit = sreg[7:1] == `DAR_PROG_ADDR;
  wire app_hit  = sreg[7:1] == app_addr;
  wire addr_ack = (prog_hit & ~sreg[0]) | app_hit;
  wire pm_full  = pm_ptr[`DAR_PMEM_AW];
  wire legal    = !sreg[7] && sreg[6:0] >= `DAR_ADDR_MIN &&
                  sreg[6:0] <= `DAR_ADDR_MAX;

  always @* begin
    case (ptr)
      `DAR_REG_CTRL:     rd_data = ctrl;
      `DAR_REG_FSD:      rd_data = fsd;
      `DAR_REG_PERIOD:   rd_data = period;
      `DAR_REG_ADDR:     rd_data = {1'b0, app_addr};
      `DAR_REG_THRESH:   rd_data = thresh;
      `DAR_REG_RANGE_LO: rd_data = range_mm[7:0];
      `DAR_REG_RANGE_HI: rd_data = range_mm[15:8];
      default:           rd_data = {5'h00, busy, fw_loaded, new_flag};
    endcase
    case (ptr)
      `DAR_REG_CTRL, `DAR_REG_FSD, `DAR_REG_PERIOD, `DAR_REG_THRESH:
        reg_ok = 1'b1;
      `DAR_REG_ADDR: reg_ok = legal;
      default:       reg_ok = 1'b0;
    endcase
  end

  // Memory has no reset, so it sits in its own process
  always @(posedge clk) begin
    fw_rd_data <= pmem[fw_rd_addr];
    if (state == S_RXHOLD && hold == STRETCH_END && !first && to_prog &&
        !pm_full)
      pmem[pm_ptr[5:0]] <= sreg;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;  bitcnt <= 4'h0;  sreg <= 8'h00;  txbuf <= 8'h00;
      hold <= 5'h00;    first <= 1'b0;   is_read <= 1'b0; to_prog <= 1'b0;
      ack_bit <= 1'b0;  m_ack <= 1'b0;   ptr <= 3'h0;     ptr_set <= 1'b0;
      pm_ptr <= 7'h00;  pm_wrote <= 1'b0; scl_oe <= 1'b0; sda_oe <= 1'b0;
      ctrl <= `DAR_CTRL_RST;     fsd <= `DAR_FSD_RST;
      period <= `DAR_PERIOD_RST; thresh <= `DAR_THRESH_RST;
      app_addr <= `DAR_APP_ADDR_RST;
      addr_pend <= `DAR_APP_ADDR_RST;
      addr_upd <= 1'b0; rd_clr <= 1'b0; fw_loaded <= 1'b0;
    end else begin
      rd_clr <= 1'b0;
      if (bus_stop) begin
        state <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        // Address swap waits for stop so the ack in flight stays valid
        if (addr_upd) app_addr <= addr_pend;
        addr_upd <= 1'b0;
        if (pm_wrote) fw_loaded <= 1'b1;
        pm_wrote <= 1'b0;
      end else if (bus_start) begin
        state <= S_RX;
        bitcnt <= 4'h0;
        first <= 1'b1;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_RX: begin
            if (scl_rise) begin
              sreg <= {sreg[6:0], sda_q[1]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              state <= S_RXHOLD;
              scl_oe <= 1'b1;
              hold <= 5'h00;
            end
          end
          S_RXHOLD: begin
            hold <= hold + 5'h01;
            if (hold == STRETCH_END) begin
              state <= S_RXACK;
              scl_oe <= 1'b0;
              if (first) begin
                ack_bit <= addr_ack;
                sda_oe <= addr_ack;
                to_prog <= prog_hit;
                is_read <= sreg[0];
                ptr_set <= 1'b0;
                if (app_hit && sreg[0]) begin
                  txbuf <= rd_data;
                  ptr <= ptr + 3'h1;
                  rd_clr <= ptr == `DAR_REG_RANGE_HI;
                end
              end else if (to_prog) begin
                ack_bit <= ~pm_full;
                sda_oe <= ~pm_full;
                if (!pm_full) begin
                  pm_ptr <= pm_ptr + 7'h01;
                  pm_wrote <= 1'b1;
                end
              end else if (!ptr_set) begin
                ptr <= sreg[2:0];
                ptr_set <= 1'b1;
                ack_bit <= sreg[7:3] == 5'h00;
                sda_oe <= sreg[7:3] == 5'h00;
              end else begin
                ack_bit <= reg_ok;
                sda_oe <= reg_ok;
                ptr <= ptr + 3'h1;
                if (reg_ok) begin
                  case (ptr)
                    `DAR_REG_CTRL:   ctrl <= sreg;
                    `DAR_REG_FSD:    fsd <= sreg;
                    `DAR_REG_PERIOD: period <= sreg;
                    `DAR_REG_THRESH: thresh <= sreg;
                    default: begin
                      addr_pend <= sreg[6:0];
                      addr_upd <= 1'b1;
                    end
                  endcase
                end
              end
            end
          end
          S_RXACK: begin
            if (scl_fall) begin
              first <= 1'b0;
              bitcnt <= 4'h0;
              if (!ack_bit) begin
                state <= S_WAIT;
                sda_oe <= 1'b0;
              end else if (is_read) begin
                state <= S_TX;
                sreg <= txbuf;
                sda_oe <= ~txbuf[7];
              end else begin
                state <= S_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                state <= S_TXHOLD;
                sda_oe <= 1'b0;
                scl_oe <= 1'b1;
                hold <= 5'h00;
                txbuf <= rd_data;
                ptr <= ptr + 3'h1;
                rd_clr <= ptr == `DAR_REG_RANGE_HI;
              end else begin
                sreg <= {sreg[6:0], 1'b0};
                sda_oe <= ~sreg[6];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          S_TXHOLD: begin
            hold <= hold + 5'h01;
            if (hold == STRETCH_END) begin
              state <= S_TXACK;
              scl_oe <= 1'b0;
            end
          end
          S_TXACK: begin
            if (scl_rise) m_ack <= ~sda_q[1];
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (m_ack) begin
                state <= S_TX;
                sreg <= txbuf;
                sda_oe <= ~txbuf[7];
              end else begin
                state <= S_WAIT;
              end
            end
          end
          S_WAIT: state <= S_WAIT;
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ranging sequencer on the shared 1 us timebase
  reg [3:0]  mstate;
  reg [6:0]  tick_cnt;
  reg [9:0]  ms_cnt;
  reg [7:0]  per_cnt;
  reg [9:0]  dly;
  reg [15:0] tof;
  reg [15:0] echo_tof;
  reg        got;
  reg [15:0] last_range;
  reg [6:0]  int_cnt;

  wire        trig_mode = ctrl[`DAR_CTRL_TRIG];
  wire [1:0]  int_cfg   = ctrl[`DAR_CTRL_CFG_HI:`DAR_CTRL_CFG_LO];
  wire        armed     = ctrl[`DAR_CTRL_EN] & fw_loaded;
  wire        tick      = tick_cnt == TICK_END;
  wire        ms_tick   = tick & (ms_cnt == MS_END);
  wire [15:0] listen_us = cm_to_round_us(fsd);
  wire [15:0] new_mm    = got ? tof_to_mm(echo_tof) : `DAR_NO_ECHO;
  wire [15:0] lim_mm    = {5'h00, thresh, 3'h0} + {7'h00, thresh, 1'b0};
  wire [15:0] delta     = new_mm > last_range ? new_mm - last_range
                                              : last_range - new_mm;
  reg         fire;

  assign int_oe = ~trig_mode;

  always @* begin
    case (int_cfg)
      `DAR_CFG_PROX:   fire = got && new_mm < lim_mm;
      `DAR_CFG_MOTION: fire = delta > lim_mm;
      default:         fire = 1'b1;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mstate <= M_IDLE;  tick_cnt <= 7'h00; ms_cnt <= 10'h000;
      per_cnt <= 8'h00;  dly <= 10'h000;    tof <= 16'h0000;
      echo_tof <= 16'h0000; got <= 1'b0;    last_range <= `DAR_NO_ECHO;
      range_mm <= `DAR_NO_ECHO; new_flag <= 1'b0; int_cnt <= 7'h00;
      int_out <= 1'b0;   tx_burst <= 1'b0;  busy <= 1'b0;
    end else begin
      tick_cnt <= tick ? 7'h00 : tick_cnt + 7'h01;
      if (tick) ms_cnt <= ms_tick ? 10'h000 : ms_cnt + 10'h001;
      if (int_cnt != 7'h00) int_cnt <= int_cnt - 7'h01;
      int_out <= int_cnt != 7'h00 && !trig_mode;
      if (rd_clr) new_flag <= 1'b0;
      case (mstate)
        M_IDLE: begin
          busy <= 1'b0;
          if (ms_tick && per_cnt != 8'hff) per_cnt <= per_cnt + 8'h01;
          if (armed && trig_mode && int_q[1] && !int_q[2]) begin
            mstate <= M_DELAY;
            dly <= 10'h000;
            busy <= 1'b1;
          end else if (armed && !trig_mode && per_cnt >= period &&
                       period != 8'h00) begin
            mstate <= M_BURST;
            tick_cnt <= 7'h00;
            tof <= 16'h0000;
            tx_burst <= 1'b1;
            busy <= 1'b1;
          end
        end
        M_DELAY: begin
          dly <= dly + 10'h001;
          if (dly == TRIG_END) begin
            mstate <= M_BURST;
            tick_cnt <= 7'h00;
            tof <= 16'h0000;
            tx_burst <= 1'b1;
          end
        end
        M_BURST: begin
          if (tick) tof <= tof + 16'h0001;
          got <= 1'b0;
          // Leave on the tick that completes the burst: exactly its ticks
          if (tick && tof >= `DAR_BURST_US - 16'h0001) begin
            mstate <= M_LISTEN;
            tx_burst <= 1'b0;
          end
        end
        M_LISTEN: begin
          if (tick) tof <= tof + 16'h0001;
          // Only the first echo is kept; later echoes are ignored
          if (echo_q[1] && !got) begin
            got <= 1'b1;
            echo_tof <= tof;
          end
          if (tof >= listen_us) begin
            mstate <= M_IDLE;
            per_cnt <= 8'h00;
            range_mm <= new_mm;
            last_range <= new_mm;
            new_flag <= 1'b1;
            if (fire && !trig_mode) int_cnt <= INT_LEN;
          end
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end

endmodule // dar_top

// *** rtl/dar_consts.vh ***
// Purpose: Constants for the dual address I2C ranging slave.
// Assumes: 100 MHz core clock, 1 us timebase tick.
// Notes:   Times are given in their own unit, all but the burst with a derived cycle count.
// Notes on behaviour
// - Acts only as an I2C slave; never starts bus traffic.
// - Fixed address 0x45 accepts writes into program memory only.
// - Application address resets to 0x29; host may reprogram it.
// - Sending: hold SCL low after bit 8 until next byte loaded.
// - After release, sample master ack; continue on ack, stop on nack.
// - Receiving: hold SCL after bit 8, decide ack or nack, release.
// - One timebase sets sample rate and times the echo flight.
// - Once configured, measures alone and raises a wake-up interrupt.
// - Interrupt may be set to fire on motion or on proximity.
// - Range is flight time times 343 m/s, halved.
// - Full scale distance sets listening length, hence cycle time.
// - Full scale distance is one-way distance to farthest target.
// - Report the earliest echo, the first target in view.
// - Measurements may also be started by an external trigger.
// - Free-running: interrupt pin is output, pulses on new sample.
// - Triggered: host pulses pin; start after fixed delay from rise.
`ifndef DAR_CONSTS_VH
`define DAR_CONSTS_VH

`define DAR_PROG_ADDR      7'h45
`define DAR_APP_ADDR_RST   7'h29
`define DAR_ADDR_MIN       7'h08
`define DAR_ADDR_MAX       7'h77

`define DAR_CLK_NS         10
`define DAR_STRETCH_NS     200
`define DAR_STRETCH_CYC    ((`DAR_STRETCH_NS + `DAR_CLK_NS - 1) / `DAR_CLK_NS)
`define DAR_TICK_NS        1000
`define DAR_TICK_CYC       (`DAR_TICK_NS / `DAR_CLK_NS)
`define DAR_TICKS_PER_MS   1000
`define DAR_TRIG_DELAY_NS  5000
`define DAR_TRIG_CYC       ((`DAR_TRIG_DELAY_NS + `DAR_CLK_NS - 1) / `DAR_CLK_NS)
`define DAR_INT_PULSE_NS   1000
`define DAR_INT_CYC        ((`DAR_INT_PULSE_NS + `DAR_CLK_NS - 1) / `DAR_CLK_NS)
`define DAR_BURST_US       16'h0064
`define DAR_SOUND_MPS      26'h0000157
`define DAR_MM_DIV         26'h00007d0
`define DAR_CM_TO_US_MUL   24'h004e20
`define DAR_SOUND_MPS24    24'h000157

`define DAR_PMEM_DEPTH     64
`define DAR_PMEM_AW        6

`define DAR_REG_CTRL       3'h0
`define DAR_REG_FSD        3'h1
`define DAR_REG_PERIOD     3'h2
`define DAR_REG_ADDR       3'h3
`define DAR_REG_THRESH     3'h4
`define DAR_REG_RANGE_LO   3'h5
`define DAR_REG_RANGE_HI   3'h6
`define DAR_REG_STATUS     3'h7

`define DAR_CTRL_EN        0
`define DAR_CTRL_TRIG      1
`define DAR_CTRL_CFG_LO    2
`define DAR_CTRL_CFG_HI    3
`define DAR_CTRL_RST       8'h00
`define DAR_FSD_RST        8'h64
`define DAR_PERIOD_RST     8'h28
`define DAR_THRESH_RST     8'h32
`define DAR_NO_ECHO        16'hffff

`define DAR_CFG_SAMPLE     2'h0
`define DAR_CFG_PROX       2'h1
`define DAR_CFG_MOTION     2'h2

`endif

// *** tb/dar_props.sv ***
// Purpose: Port-level temporal checks for the ranging slave.
// Assumes: One clk domain; nrst low clears the design.
// Notes:   Counters time stretch, interrupt pulse and burst.
`timescale 1ns/1ns
`include "dar_consts.vh"
module dar_props (
  input wire        clk,
  input wire        nrst,
  input wire        scl_in,
  input wire        scl_oe,
  input wire        sda_in,
  input wire        sda_oe,
  input wire        int_in,
  input wire        int_out,
  input wire        int_oe,
  input wire        tx_burst,
  input wire [15:0] range_mm,
  input wire        fw_loaded,
  input wire [6:0]  app_addr
);
  reg [15:0] s_cnt;
  reg [15:0] i_cnt;
  reg [15:0] b_cnt;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_cnt <= 16'h0000;
      i_cnt <= 16'h0000;
      b_cnt <= 16'h0000;
    end else begin
      s_cnt <= scl_oe ? s_cnt + 16'h0001 : 16'h0000;
      i_cnt <= int_out ? i_cnt + 16'h0001 : 16'h0000;
      b_cnt <= tx_burst ? b_cnt + 16'h0001 : 16'h0000;
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  AST_STRETCH_LOW:
  assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("stretch began with scl high");
  AST_SDA_STABLE:
  assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  AST_STRETCH_LEN:
  assert property ($fell(scl_oe) |-> s_cnt == `DAR_STRETCH_CYC)
    else $error("stretch length wrong");
  AST_FW_KEEP:
  assert property (!$fell(fw_loaded))
    else $error("fw_loaded dropped");
  AST_ADDR_AT_STOP:
  assert property ($changed(app_addr) |-> scl_in && sda_in &&
    app_addr >= `DAR_ADDR_MIN && app_addr <= `DAR_ADDR_MAX)
    else $error("app_addr changed badly");
  AST_INT_PULSE:
  assert property ($fell(int_out) |-> i_cnt == `DAR_INT_CYC)
    else $error("interrupt pulse length wrong");
  AST_INT_DRIVEN:
  assert property (int_out |-> int_oe)
    else $error("interrupt pulse while pin not driven");
  AST_TRIG_DELAY:
  assert property ($rose(int_in) && !int_oe && fw_loaded
                   |-> ##[500:510] $rose(tx_burst))
    else $error("trigger to burst delay wrong");
  AST_BURST_LEN:
  assert property ($fell(tx_burst) |->
    b_cnt == `DAR_BURST_US * `DAR_TICK_CYC)
    else $error("burst length wrong");
  AST_BURST_FW:
  assert property ($rose(tx_burst) |-> fw_loaded)
    else $error("burst without firmware");
  AST_RANGE_QUIET:
  assert property ($changed(range_mm) |-> !tx_burst)
    else $error("range updated during burst");
  COV_STRETCH: cover property ($fell(scl_oe));
  COV_BURST: cover property ($rose(tx_burst));
  COV_FW: cover property ($rose(fw_loaded));
endmodule // dar_props

bind dar_top dar_props dar_props_inst (
  .clk(clk), .nrst(nrst), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_oe(sda_oe), .int_in(int_in),
  .int_out(int_out), .int_oe(int_oe), .tx_burst(tx_burst),
  .range_mm(range_mm), .fw_loaded(fw_loaded), .app_addr(app_addr)
);

// *** tb/dar_host.sv ***
// Purpose: I2C master model standing for the host processor.
// Assumes: Bench resolves the open-drain wires with pull-ups.
// Notes:   Half bit is 8 clk; seeing SCL rise adds 1 clk, a 170 ns SCL period.
`timescale 1ns/1ns
module dar_host (
  input  wire clk,
  input  wire scl,
  input  wire sda,
  output reg  scl_low,
  output reg  sda_low,
  output reg  stuck
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end
  task hp;
    repeat (8) @(negedge clk);
  endtask
  // The slave stretches before each ack slot until a nack, so never assume SCL rose
  task rise;
    integer n;
    begin
      scl_low = 1'b0;
      n = 0;
      @(negedge clk);
      while (!scl && n < 100) begin
        @(negedge clk);
        n = n + 1;
      end
      if (!scl)
        stuck = 1'b1;
    end
  endtask
  task bit_out(input b);
    begin
      sda_low = ~b;
      hp;
      rise;
      hp;
      scl_low = 1'b1;
    end
  endtask
  task bit_in(output b);
    begin
      sda_low = 1'b0;
      hp;
      rise;
      b = sda;
      hp;
      scl_low = 1'b1;
    end
  endtask
  task wr(input [7:0] d, output ack);
    integer i;
    reg b;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_out(d[i]);
      bit_in(b);
      ack = ~b;
    end
  endtask
  task rd(input nack, output [7:0] d);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_in(d[i]);
      bit_out(nack);
    end
  endtask
  task start;
    begin
      sda_low = 1'b0;
      hp;
      rise;
      hp;
      sda_low = 1'b1;
      hp;
      scl_low = 1'b1;
    end
  endtask
  task stop;
    begin
      sda_low = 1'b1;
      hp;
      rise;
      hp;
      sda_low = 1'b0;
      hp;
    end
  endtask
endmodule // dar_host

// *** tb/dual_address_i2c_ranging_slave_test.sv ***
// Purpose: Self-checking bench for the dual address ranging slave.
// Assumes: Host model on the I2C wires, bench on echo and trigger.
// Notes:   Small full scale distance keeps each measurement short.
`timescale 1ns/1ns
`include "dar_consts.vh"
module dual_address_i2c_ranging_slave_test;
  reg         clk;
  reg         nrst;
  reg         int_in;
  reg         echo_in;
  reg  [5:0]  fw_rd_addr;
  wire        scl_oe, sda_oe, m_scl, m_sda, stuck, int_oe, tx_burst;
  wire        fw_loaded;
  wire [15:0] range_mm;
  wire [6:0]  app_addr;
  wire [7:0]  fw_rd_data;
  wire        scl = ~(m_scl | scl_oe);
  wire        sda = ~(m_sda | sda_oe);
  integer     err_count, n_compared, lat1, lat2;
  reg  [2:0]  k3;
  reg         k;
  reg  [15:0] d;
  dar_top dar_top_inst (
    .clk(clk), .nrst(nrst), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .int_in(int_in),
    .int_out(), .int_oe(int_oe), .echo_in(echo_in),
    .tx_burst(tx_burst), .range_mm(range_mm), .fw_loaded(fw_loaded),
    .app_addr(app_addr), .fw_rd_addr(fw_rd_addr),
    .fw_rd_data(fw_rd_data));
  dar_host dar_host_inst (.clk(clk), .scl(scl), .sda(sda),
    .scl_low(m_scl), .sda_low(m_sda), .stuck(stuck));
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  task chk(input string name, input [15:0] exp, input [15:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task dev_wr(input [6:0] a, input [7:0] p, input [7:0] v,
              output [2:0] acks);
    begin
      dar_host_inst.start;
      dar_host_inst.wr({a, 1'b0}, acks[2]);
      dar_host_inst.wr(p, acks[1]);
      dar_host_inst.wr(v, acks[0]);
      dar_host_inst.stop;
    end
  endtask
  // Low byte acked, high byte nacked, then SDA must be let go
  task dev_rd(input [6:0] a, input [7:0] p, output [15:0] v);
    begin
      dar_host_inst.start;
      dar_host_inst.wr({a, 1'b0}, k);
      dar_host_inst.wr(p, k);
      dar_host_inst.start;
      dar_host_inst.wr({a, 1'b1}, k);
      dar_host_inst.rd(1'b0, v[7:0]);
      dar_host_inst.rd(1'b1, v[15:8]);
      repeat (8) @(negedge clk);
      chk("sda_release", 16'h0000, {15'h0000, sda_oe});
      dar_host_inst.stop;
    end
  endtask
  task echo(input integer gap);
    begin
      repeat (gap) @(negedge clk);
      echo_in = 1'b1;
      repeat (100) @(negedge clk);
      echo_in = 1'b0;
    end
  endtask
  // Two echoes 2000 clk apart; only the first may be reported
  task measure(input integer at, output integer lat);
    begin
      int_in = 1'b1;
      lat = 0;
      while (!tx_burst && lat < 1000) begin
        @(negedge clk);
        lat = lat + 1;
      end
      int_in = 1'b0;
      echo(at);
      echo(1900);
      repeat (33000 - at - 2100) @(negedge clk);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    int_in = 1'b0;
    echo_in = 1'b0;
    fw_rd_addr = 6'h00;
    err_count = 0;
    n_compared = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    chk("app_addr", {9'h000, `DAR_APP_ADDR_RST}, {9'h000, app_addr});
    chk("fw_rst", 16'h0000, {15'h0000, fw_loaded});
    chk("range_rst", `DAR_NO_ECHO, range_mm);
    dev_wr(7'h30, 8'h00, 8'h00, k3);
    chk("foreign_acks", 16'h0000, {13'h0000, k3});
    dar_host_inst.start;
    dar_host_inst.wr({`DAR_PROG_ADDR, 1'b1}, k);
    dar_host_inst.stop;
    chk("prog_rd_ack", 16'h0000, {15'h0000, k});
    dev_wr(`DAR_PROG_ADDR, 8'ha5, 8'h3c, k3);
    chk("prog_acks", 16'h0007, {13'h0000, k3});
    chk("fw_loaded", 16'h0001, {15'h0000, fw_loaded});
    repeat (2) @(negedge clk);
    chk("pmem0", 16'h00a5, {8'h00, fw_rd_data});
    fw_rd_addr = 6'h01;
    repeat (2) @(negedge clk);
    chk("pmem1", 16'h003c, {8'h00, fw_rd_data});
    dev_wr(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_FSD}, 8'h05, k3);
    chk("fsd_acks", 16'h0007, {13'h0000, k3});
    dev_wr(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_ADDR}, 8'h78, k3);
    chk("bad_addr", 16'h0006, {13'h0000, k3});
    dev_wr(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_RANGE_LO}, 8'h11, k3);
    chk("ro_write", 16'h0006, {13'h0000, k3});
    dev_rd(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_FSD}, d);
    chk("fsd_period", {`DAR_PERIOD_RST, 8'h05}, d);
    dev_wr(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_CTRL}, 8'h03, k3);
    chk("int_oe", 16'h0000, {15'h0000, int_oe});
    measure(20000, lat1);
    dev_rd(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_RANGE_LO}, d);
    chk("range_near", 16'h0022, d);
    measure(30000, lat2);
    dev_rd(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_STATUS}, d);
    chk("status_new", 16'h0303, d);
    dev_rd(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_RANGE_LO}, d);
    chk("range_far", `DAR_NO_ECHO, d);
    chk("trig_same", lat1[15:0], lat2[15:0]);
    chk("trig_win", 16'h0001, {15'h0000, lat1 >= 500 && lat1 <= 510});
    dev_wr(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_ADDR}, 8'h3a, k3);
    chk("new_addr", 16'h003a, {9'h000, app_addr});
    dev_wr(`DAR_APP_ADDR_RST, {5'h00, `DAR_REG_CTRL}, 8'h00, k3);
    chk("old_addr", 16'h0000, {13'h0000, k3});
    dev_wr(7'h3a, {5'h00, `DAR_REG_CTRL}, 8'h00, k3);
    chk("new_acks", 16'h0007, {13'h0000, k3});
    chk("stretch_end", 16'h0000, {15'h0000, stuck});
    complete_run;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count = err_count + 1;
    $display("mismatch watchdog expected done seen hang");
    complete_run;
  end
endmodule // dual_address_i2c_ranging_slave_test
